// File: hw/ctd_decoder.sv
// instruction timing and register-mode extension word decoder with apb status port
// assumes program memory offers one word per cycle on fetch_valid and waits on fetch_ready;
// the core supplies the low nibble of the register named on repeat_reg_sel
//
// Design decisions made here: the address map and the APB interface to the registers.

`timescale 1ns/100ps

module ctd_decoder
	import ctd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        fetch_valid,
	input  wire logic [15:0] fetch_word,
	output logic             fetch_ready,
	input  wire logic        status_carry,
	input  wire logic  [3:0] repeat_reg_nibble,
	output logic       [3:0] repeat_reg_sel,
	output logic             dec_valid,
	output ctd_dec_t         dec_info,
	output logic             exec_active,
	output logic             carry_in_eff,
	output logic             carry_from_final,
	output logic             instr_done
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ctd_state_t  state_q;
	ctd_state_t  state_d;
	logic  [2:0] cyc_left_q;
	logic  [2:0] cyc_load_q;
	logic  [3:0] rep_left_q;
	logic        zc_run_q;
	logic        ext_pend_q;
	logic [15:0] ext_word_q;
	logic        fetch_ready_q;
	logic        dec_valid_q;
	ctd_dec_t    dec_info_q;
	logic        carry_in_q;
	logic        carry_final_q;
	logic        done_q;
	logic        ctrl_en_q;
	logic [15:0] instr_cnt_q;
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;

	// ------------------------------------------------------------
	// fetch classification
	// ------------------------------------------------------------
	logic        fetch_take;
	logic        word_is_ext;
	logic        instr_take;
	logic  [3:0] w_op;
	logic  [3:0] w_rs;
	logic  [3:0] w_rd;
	logic  [1:0] w_as;
	logic        w_ad;
	logic        w_bw;
	logic        is_jump;
	logic        is_fmt1;
	logic        is_fmt2;
	logic        is_xnoext;
	ctd_kind_t   kind;

	assign fetch_take  = fetch_valid & fetch_ready_q;
	assign word_is_ext = fetch_word[15:11] == EXT_OPC;
	assign instr_take  = fetch_take & ~word_is_ext;
	assign w_op        = fetch_word[15:12];
	assign w_rs        = fetch_word[11:8];
	assign w_rd        = fetch_word[3:0];
	assign w_as        = fetch_word[5:4];
	assign w_ad        = fetch_word[AD_BIT];
	assign w_bw        = fetch_word[BW_BIT];
	assign is_jump     = fetch_word[15:13] == JMP_PFX;
	assign is_fmt1     = w_op >= FMT1_MIN;
	assign is_fmt2     = fetch_word[15:10] == FMT2_PFX;
	assign is_xnoext   = w_op == XNOEXT_OP;
	assign kind        = is_jump ? K_JUMP : is_fmt1 ? K_FMT1 : is_fmt2 ? K_FMT2 : K_OTHER;

	// ------------------------------------------------------------
	// addressing modes
	// ------------------------------------------------------------
	// constant generator sources decode as register timing, they fetch no word
	logic        rs_cg;
	ctd_src_t    src_mode;
	ctd_dst_t    dst_mode;

	assign rs_cg    = (w_rs == REG_SR) | (w_rs == REG_CG2);
	assign src_mode = (w_as == AS_REG) ? S_REG :
	                  (w_as == AS_IDX) ? ((w_rs == REG_PC)  ? S_SYM :
	                                      (w_rs == REG_SR)  ? S_ABS :
	                                      (w_rs == REG_CG2) ? S_REG : S_IDX) :
	                  (w_as == AS_IND) ? (rs_cg ? S_REG : S_IND) :
	                  (w_rs == REG_PC) ? S_IMM : (rs_cg ? S_REG : S_AUTO);
	assign dst_mode = w_ad ? D_MEM : ((w_rd == REG_PC) ? D_PC : D_REG);

	// ------------------------------------------------------------
	// double operand timing, operation independent except the write-back saving
	// ------------------------------------------------------------
	function automatic logic [4:0] fmt1_timing(input ctd_src_t s, input ctd_dst_t d);
		logic [2:0] c;
		logic [1:0] l;
		c = CYC_R_R;
		l = LEN_1W;
		unique case (s)
			S_REG: begin
				c = (d == D_REG) ? CYC_R_R : (d == D_PC) ? CYC_R_PC : CYC_R_M;
				l = (d == D_MEM) ? LEN_2W : LEN_1W;
			end
			S_IND, S_AUTO: begin
				c = (d == D_REG) ? CYC_I_R : (d == D_PC) ? CYC_I_PC : CYC_I_M;
				l = (d == D_MEM) ? LEN_2W : LEN_1W;
			end
			S_IMM: begin
				c = (d == D_REG) ? CYC_I_R : (d == D_PC) ? CYC_I_PC : CYC_I_M;
				l = (d == D_MEM) ? LEN_3W : LEN_2W;
			end
			S_IDX, S_SYM, S_ABS: begin
				c = (d == D_REG) ? CYC_X_R : (d == D_PC) ? CYC_X_PC : CYC_X_M;
				l = (d == D_MEM) ? LEN_3W : LEN_2W;
			end
			default: begin
				c = CYC_R_R;
				l = LEN_1W;
			end
		endcase
		return {c, l};
	endfunction

	logic  [4:0] f1_tim;
	logic        no_wb;
	logic  [2:0] f1_cyc;
	logic  [2:0] dec_cyc;
	logic  [1:0] dec_len;

	assign f1_tim  = fmt1_timing(src_mode, dst_mode);
	assign no_wb   = (w_op == OP_MOVE) | (w_op == OP_COMPARE) | (w_op == OP_BITTEST);
	assign f1_cyc  = (no_wb & (dst_mode == D_MEM)) ? f1_tim[4:2] - CYC_ONE : f1_tim[4:2];
	// single-operand and other forms are timed elsewhere; a plain one-cycle default is given
	assign dec_cyc = is_jump ? CYC_JUMP : is_fmt1 ? f1_cyc : CYC_OTHER;
	assign dec_len = is_fmt1 ? f1_tim[1:0] : LEN_1W;

	// ------------------------------------------------------------
	// extension word application
	// ------------------------------------------------------------
	logic        reg_form;
	logic        reg_ext;
	logic  [3:0] rep_m1;
	logic        zc_sel;
	logic        al_bit;
	ctd_width_t  width;
	logic        addr20;

	assign reg_form = (is_fmt1 & (w_as == AS_REG) & ~w_ad) | (is_fmt2 & (w_as == AS_REG));
	assign reg_ext  = ext_pend_q & reg_form;
	// bits 10:9 and 5:4 of the held word are never looked at
	assign rep_m1   = ~reg_ext ? 4'h0 :
	                  ext_word_q[EXT_REP_BIT] ? repeat_reg_nibble : ext_word_q[3:0];
	assign zc_sel   = reg_ext & ext_word_q[EXT_ZC_BIT];
	assign al_bit   = ext_pend_q ? ext_word_q[EXT_AL_BIT] : 1'b1;
	assign width    = (is_fmt1 | is_fmt2) ? ctd_width_t'({al_bit, w_bw}) : W_WORD;
	assign addr20   = ext_pend_q | is_xnoext;

	ctd_dec_t    dec_now;

	always_comb begin
		dec_now            = '0;
		dec_now.kind       = kind;
		dec_now.rep_m1     = rep_m1;
		dec_now.carry_zero = zc_sel;
		dec_now.reg_ext    = reg_ext;
		dec_now.addr20     = addr20;
		dec_now.width      = width;
		dec_now.words      = dec_len;
		dec_now.cycles     = dec_cyc;
	end

	// ------------------------------------------------------------
	// execution sequencer
	// ------------------------------------------------------------
	logic        cyc_end;
	logic        last_rep;
	logic        run_end;

	assign cyc_end  = (state_q == ST_RUN) & (cyc_left_q == 3'h0);
	assign last_rep = rep_left_q == 4'h0;
	assign run_end  = cyc_end & last_rep;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (instr_take) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (run_end) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			cyc_left_q <= 3'h0;
			cyc_load_q <= 3'h0;
			rep_left_q <= 4'h0;
			zc_run_q   <= 1'b0;
		end else if (instr_take) begin
			state_q    <= state_d;
			cyc_left_q <= dec_cyc - CYC_ONE;
			cyc_load_q <= dec_cyc - CYC_ONE;
			rep_left_q <= rep_m1;
			zc_run_q   <= zc_sel;
		end else begin
			state_q <= state_d;
			if (run_end) begin
				rep_left_q <= 4'h0;
				zc_run_q   <= 1'b0;
			end else if (cyc_end) begin
				rep_left_q <= rep_left_q - 4'h1;
				cyc_left_q <= cyc_load_q;
			end else if (state_q == ST_RUN) begin
				cyc_left_q <= cyc_left_q - 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// extension capture and decode outputs
	// ------------------------------------------------------------
	// an extension word costs no execution cycle here; a second one replaces the first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_pend_q <= 1'b0;
			ext_word_q <= 16'h0000;
		end else if (fetch_take) begin
			ext_pend_q <= word_is_ext;
			if (word_is_ext) begin
				ext_word_q <= fetch_word;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dec_valid_q   <= 1'b0;
			dec_info_q    <= '0;
			fetch_ready_q <= 1'b0;
			done_q        <= 1'b0;
			carry_in_q    <= 1'b0;
			carry_final_q <= 1'b0;
		end else begin
			dec_valid_q   <= instr_take;
			fetch_ready_q <= ctrl_en_q & (state_d == ST_IDLE);
			done_q        <= run_end;
			// carry input is forced to zero for the whole run when zero-carry is set
			carry_in_q    <= (state_d == ST_RUN) & (instr_take ? zc_sel : zc_run_q)
			                 ? 1'b0 : status_carry;
			carry_final_q <= (state_d == ST_RUN) & (instr_take ? (zc_sel & (rep_m1 == 4'h0))
			                 : (zc_run_q & (rep_left_q == 4'h0 | (cyc_end & rep_left_q == 4'h1))));
			if (instr_take) begin
				dec_info_q <= dec_now;
			end
		end
	end

	// ------------------------------------------------------------
	// apb slave: one wait state, writes commit on the completing edge
	// ------------------------------------------------------------
	logic        apb_acc;
	logic        apb_done;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_last;
	logic        hit_count;
	logic        hit_any;
	logic [31:0] rd_mux;
	logic        wr_ctrl;

	assign apb_acc    = psel & penable & ~pready_q;
	assign apb_done   = psel & penable & pready_q;
	assign hit_ctrl   = paddr == OFS_CTRL;
	assign hit_status = paddr == OFS_STATUS;
	assign hit_last   = paddr == OFS_LAST;
	assign hit_count  = paddr == OFS_COUNT;
	assign hit_any    = hit_ctrl | hit_status | hit_last | hit_count;
	assign wr_ctrl    = apb_done & pwrite & hit_ctrl;
	assign rd_mux     = hit_ctrl   ? {30'h0, 1'b0, ctrl_en_q} :
	                    hit_status ? {24'h0, rep_left_q, ext_pend_q, fetch_ready_q,
	                                  done_q, state_q} :
	                    hit_last   ? {16'h0, dec_info_q} :
	                    hit_count  ? {16'h0, instr_cnt_q} : 32'h0;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= apb_acc;
			pslverr_q <= apb_acc & ~hit_any;
			prdata_q  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// clear-count and a new decode in the same cycle: the decode is kept
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_en_q   <= CTRL_EN_RST;
			instr_cnt_q <= 16'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_en_q <= pwdata[CTRL_EN_BIT];
			end
			if (instr_take) begin
				instr_cnt_q <= (wr_ctrl & pwdata[CTRL_CLR_BIT]) ? 16'h1 : instr_cnt_q + 16'h1;
			end else if (wr_ctrl & pwdata[CTRL_CLR_BIT]) begin
				instr_cnt_q <= 16'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pready           = pready_q;
	assign prdata           = prdata_q;
	assign pslverr          = pslverr_q;
	assign fetch_ready      = fetch_ready_q;
	assign repeat_reg_sel   = ext_word_q[3:0];
	assign dec_valid        = dec_valid_q;
	assign dec_info         = dec_info_q;
	assign exec_active      = state_q;
	assign carry_in_eff     = carry_in_q;
	assign carry_from_final = carry_final_q;
	assign instr_done       = done_q;

endmodule

// File: hw/ctd_pkg.sv
// constants, codes and carriers for the cycle timing and extension word decoder
// assumes a 16-bit instruction stream and a 32-bit apb register port
package ctd_pkg;

	// ------------------------------------------------------------
	// apb register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_LAST   = 12'h008;
	localparam logic [11:0] OFS_COUNT  = 12'h00C;
	localparam int          CTRL_EN_BIT  = 0;
	localparam int          CTRL_CLR_BIT = 1;
	localparam logic        CTRL_EN_RST  = 1'b1;

	// ------------------------------------------------------------
	// instruction word fields
	// ------------------------------------------------------------
	localparam logic [4:0] EXT_OPC     = 5'h03;
	localparam logic [2:0] JMP_PFX     = 3'h1;
	localparam logic [5:0] FMT2_PFX    = 6'h04;
	localparam logic [3:0] FMT1_MIN    = 4'h4;
	localparam logic [3:0] XNOEXT_OP   = 4'h0;
	localparam logic [3:0] OP_MOVE     = 4'h4;
	localparam logic [3:0] OP_COMPARE  = 4'h9;
	localparam logic [3:0] OP_BITTEST  = 4'hB;
	localparam logic [3:0] REG_PC      = 4'h0;
	localparam logic [3:0] REG_SR      = 4'h2;
	localparam logic [3:0] REG_CG2     = 4'h3;
	localparam logic [1:0] AS_REG      = 2'h0;
	localparam logic [1:0] AS_IDX      = 2'h1;
	localparam logic [1:0] AS_IND      = 2'h2;
	localparam int         EXT_ZC_BIT  = 8;
	localparam int         EXT_REP_BIT = 7;
	localparam int         EXT_AL_BIT  = 6;
	localparam int         BW_BIT      = 6;
	localparam int         AD_BIT      = 7;

	// ------------------------------------------------------------
	// cycle counts and lengths
	// ------------------------------------------------------------
	localparam logic [2:0] CYC_JUMP  = 3'h2;
	localparam logic [2:0] CYC_OTHER = 3'h1;
	localparam logic [2:0] CYC_R_R   = 3'h1;
	localparam logic [2:0] CYC_R_PC  = 3'h2;
	localparam logic [2:0] CYC_R_M   = 3'h4;
	localparam logic [2:0] CYC_I_R   = 3'h2;
	localparam logic [2:0] CYC_I_PC  = 3'h3;
	localparam logic [2:0] CYC_I_M   = 3'h5;
	localparam logic [2:0] CYC_X_R   = 3'h3;
	localparam logic [2:0] CYC_X_PC  = 3'h3;
	localparam logic [2:0] CYC_X_M   = 3'h6;
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [1:0] LEN_1W    = 2'h1;
	localparam logic [1:0] LEN_2W    = 2'h2;
	localparam logic [1:0] LEN_3W    = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		W_RSVD   = 2'b00,
		W_ADDR20 = 2'b01,
		W_WORD   = 2'b10,
		W_BYTE   = 2'b11
	} ctd_width_t;

	typedef enum logic [1:0] {
		K_OTHER = 2'b00,
		K_JUMP  = 2'b01,
		K_FMT1  = 2'b10,
		K_FMT2  = 2'b11
	} ctd_kind_t;

	typedef enum logic [2:0] {
		S_REG  = 3'b000,
		S_IND  = 3'b001,
		S_AUTO = 3'b010,
		S_IMM  = 3'b011,
		S_IDX  = 3'b100,
		S_SYM  = 3'b101,
		S_ABS  = 3'b110
	} ctd_src_t;

	typedef enum logic [1:0] {
		D_REG = 2'b00,
		D_PC  = 2'b01,
		D_MEM = 2'b10
	} ctd_dst_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} ctd_state_t;

	typedef struct packed {
		ctd_kind_t  kind;
		logic [3:0] rep_m1;
		logic       carry_zero;
		logic       reg_ext;
		logic       addr20;
		ctd_width_t width;
		logic [1:0] words;
		logic [2:0] cycles;
	} ctd_dec_t;

endpackage

// File: dv/ctd_chk_props.sv
// port assertions for the timing and extension word decoder
// assumes it is bound to ctd_decoder; one clock, synchronous reset
`timescale 1ns/100ps
module ctd_chk
	import ctd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        fetch_valid,
	input wire logic [15:0] fetch_word,
	input wire logic        fetch_ready,
	input wire logic        status_carry,
	input wire logic        dec_valid,
	input wire ctd_dec_t    dec_info,
	input wire logic        exec_active,
	input wire logic        carry_in_eff,
	input wire logic        carry_from_final,
	input wire logic        instr_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0] run_q;
	wire  [7:0] exp_len = {5'h00, dec_info.cycles} * ({4'h0, dec_info.rep_m1} + 8'h01);
	// cycles already spent in the current run, current cycle excluded
	always_ff @(posedge clk_sys) begin
		if (rst)
			run_q <= 8'h00;
		else if (dec_valid)
			run_q <= 8'h01;
		else if (exec_active)
			run_q <= run_q + 8'h01;
	end
	property p_jump;
		dec_valid && dec_info.kind == K_JUMP |-> dec_info.cycles == CYC_JUMP
			&& dec_info.words == LEN_1W;
	endproperty
	a_jump: assert property (p_jump) else $error("jump timing wrong");
	property p_take;
		fetch_valid && fetch_ready && fetch_word[15:11] != EXT_OPC
			|=> dec_valid && exec_active && !fetch_ready ##1 !dec_valid;
	endproperty
	a_take: assert property (p_take) else $error("instruction start wrong");
	property p_ext;
		fetch_valid && fetch_ready && fetch_word[15:11] == EXT_OPC |=> !dec_valid && !exec_active;
	endproperty
	a_ext: assert property (p_ext) else $error("prefix word executed");
	property p_done;
		$fell(exec_active) |-> instr_done && fetch_ready ##1 !instr_done;
	endproperty
	a_done: assert property (p_done) else $error("completion pulse wrong");
	property p_len;
		$fell(exec_active) |-> run_q == exp_len;
	endproperty
	a_len: assert property (p_len) else $error("run length wrong");
	property p_zc;
		exec_active && dec_info.carry_zero |-> !carry_in_eff;
	endproperty
	a_zc: assert property (p_zc) else $error("carry input not zero");
	property p_fin;
		exec_active && dec_info.carry_zero && !dec_valid
			|-> carry_from_final == (run_q >= exp_len - {5'h00, dec_info.cycles});
	endproperty
	a_fin: assert property (p_fin) else $error("final repetition flag wrong");
	property p_carry;
		!exec_active && !$past(exec_active) && !$past(rst) |-> carry_in_eff == $past(status_carry);
	endproperty
	a_carry: assert property (p_carry) else $error("carry input not tracking");
	property p_other;
		dec_valid && dec_info.kind != K_FMT1 && dec_info.kind != K_FMT2
			|-> dec_info.rep_m1 == 4'h0 && !dec_info.carry_zero;
	endproperty
	a_other: assert property (p_other) else $error("repeat on non register form");
	property p_apb;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("bus wait state wrong");
	c_jump: cover property (dec_valid && dec_info.kind == K_JUMP);
	c_rep: cover property (dec_valid && dec_info.rep_m1 != 4'h0);
	c_fin: cover property (carry_from_final);
endmodule
bind ctd_decoder ctd_chk chk_u (.clk_sys, .rst, .psel, .penable, .pready, .fetch_valid,
	.fetch_word, .fetch_ready, .status_carry, .dec_valid, .dec_info, .exec_active,
	.carry_in_eff, .carry_from_final, .instr_done);

// File: dv/ctd_pmem.sv
// program memory model feeding the fetch port one word at a time
// assumes the bench queues words with put; stall holds the next word back
`timescale 1ns/100ps
module ctd_pmem (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        fetch_ready,
	output logic             fetch_valid,
	output logic      [15:0] fetch_word
);
	logic [15:0] q[$];
	logic        has;
	initial begin
		fetch_valid = 1'b0;
		fetch_word = 16'h0000;
		has = 1'b0;
	end
	task put(input logic [15:0] w);
		q.push_back(w);
	endtask
	// an offered word holds until taken; idle data toggles so no stale word looks usable
	always @(posedge clk_sys) begin
		if (rst || (fetch_valid && fetch_ready))
			has = 1'b0;
		if (!rst && !has && !stall && q.size() > 0) begin
			fetch_word <= q.pop_front();
			has = 1'b1;
		end else if (!has)
			fetch_word <= ~fetch_word;
		fetch_valid <= has;
	end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the timing and extension word decoder
// assumes the memory model and the bound checker are compiled before it
`timescale 1ns/100ps
module tb_top;
	import ctd_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        stall = 1'b0;
	logic        status_carry = 1'b0;
	logic        pready, pslverr, fetch_ready, dec_valid, exec_active, carry_in_eff;
	logic        carry_from_final, instr_done, fetch_valid, er;
	logic [31:0] prdata, r;
	logic [31:0] lf = 32'h9ED7;
	logic [15:0] fetch_word, last, e;
	logic [3:0]  repeat_reg_nibble, repeat_reg_sel;
	logic [3:0]  key = 4'h0;
	ctd_dec_t    dec_info;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          ndec = 0;
	int          cyc_n = 0;
	int          s, d;
	int          cyc_t[7][3] = '{'{1,2,4},'{2,3,5},'{2,3,5},'{2,3,5},'{3,3,6},'{3,3,6},'{3,3,6}};
	logic [1:0]  as_t[7] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};
	logic [3:0]  rs_t[7] = '{4'h5, 4'h5, 4'h5, 4'h0, 4'h5, 4'h0, 4'h2};
	logic [3:0]  ops[4] = '{OP_MOVE, OP_COMPARE, OP_BITTEST, 4'h5};
	always #20 clk_sys = ~clk_sys;
	// the core's register file: low nibble of register n is n xor key
	assign repeat_reg_nibble = repeat_reg_sel ^ key;
	ctd_decoder dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .fetch_valid, .fetch_word, .fetch_ready, .status_carry,
		.repeat_reg_nibble, .repeat_reg_sel, .dec_valid, .dec_info, .exec_active,
		.carry_in_eff, .carry_from_final, .instr_done);
	ctd_pmem pm_u (.clk_sys, .rst, .stall, .fetch_ready, .fetch_valid, .fetch_word);
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge clk_sys) begin
		lf <= nxt(lf);
		status_carry <= lf[3];
		stall <= lf[7] & lf[9];
		cyc_n++;
		if (cyc_n == 20000) begin
			error_cnt++;
			end_sim;
		end
	end
	task end_sim;
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
			error_cnt++;
		end
	endtask
	// the master waits for pready however long it takes; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [15:0] mk(logic [3:0] op, int s, int d, logic bw);
		return {op, rs_t[s], d == 2, bw, as_t[s], d == 1 ? 4'h0 : 4'h6};
	endfunction
	// expected decode: kind, reps-1, zero carry, spare, addr20, width, words, cycles
	function automatic logic [15:0] model(logic [15:0] w, bit x, logic [15:0] e);
		int k = 0, cyc = 1, wds = 1, rep = 0, zc = 0, s, d;
		logic [1:0] wd = 2'h2;
		if (w[15:13] == 3'b001) begin
			k = 1;
			cyc = 2;
		end else if (w[15:12] >= 4'h4) begin
			k = 2;
			s = w[5:4] == 2'h0 ? 0 : w[5:4] == 2'h2 ? 1 : w[5:4] == 2'h3 ? (w[11:8] == 4'h0 ? 3 : 2)
				: w[11:8] == 4'h0 ? 5 : w[11:8] == 4'h2 ? 6 : 4;
			d = w[7] ? 2 : int'(w[3:0] == 4'h0);
			cyc = cyc_t[s][d] - int'(d == 2 && w[15:12] inside {OP_MOVE, OP_COMPARE, OP_BITTEST});
			wds = int'(s > 2) + 1 + int'(d == 2);
			wd = {x ? e[6] : 1'b1, w[6]};
			if (x && w[5:4] == 2'h0 && !w[7]) begin
				zc = e[8];
				rep = e[7] ? (e[3:0] ^ key) : e[3:0];
			end
		end
		return {k[1:0], rep[3:0], zc[0], 1'b0, x || w[15:12] == 4'h0, wd, wds[1:0], cyc[2:0]};
	endfunction
	task automatic run(input bit x, input logic [15:0] e, input logic [15:0] w);
		logic [15:0] ex;
		logic        pc;
		int n, f, cb;
		ex = model(w, x, e);
		if (x)
			pm_u.put(e);
		pm_u.put(w);
		pc = 1'b0;
		do
			@(posedge clk_sys);
		while (dec_valid !== 1'b1);
		n = 0;
		f = 0;
		cb = 0;
		// carry input lags the core flag by one cycle, forced low for a zero-carry run
		while (instr_done !== 1'b1) begin
			if (exec_active === 1'b1 && (ex[9] || n > 0))
				cb += int'(carry_in_eff !== (ex[9] ? 1'b0 : pc));
			pc = status_carry;
			n += int'(exec_active === 1'b1);
			f += int'(carry_from_final === 1'b1);
			@(posedge clk_sys);
		end
		chk("dec_info", ex & 16'hFEFF, dec_info & 16'hFEFF);
		chk("exec_len", ex[2:0] * (ex[13:10] + 1), n);
		chk("final_rep", ex[9] ? ex[2:0] : 0, f);
		chk("carry_in", 32'h0, cb);
		ndec++;
		last = ex;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		key <= lf[3:0];
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, r);
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		chk("unmapped", 32'h0, r);
		apb(1'b1, OFS_CTRL, 32'h3);
		apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h4, r);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status_off", 32'h0, r);
		apb(1'b1, OFS_CTRL, 32'h1);
		for (int c = 0; c < 8; c++)
			run(1'b0, 16'h0, {3'b001, 3'(c), lf[9:0]});
		for (s = 0; s < 7; s++)
			for (d = 0; d < 3; d++)
				for (int o = 0; o < 4; o++)
					run(1'b0, 16'h0, mk(ops[o], s, d, lf[0]));
		repeat (40) begin
			e = {5'b00011, lf[10:0]};
			s = lf[13:12] == 2'h0 ? int'(lf[20:18]) % 7 : 0;
			d = int'(lf[15:14]) % 3;
			run(1'b1, e, mk(ops[lf[17:16]], s, d, lf[11]));
		end
		run(1'b0, 16'h0, {4'h0, lf[11:0]});
		apb(1'b0, OFS_LAST, 32'h0);
		chk("last", {16'h0, last & 16'hFEFF}, r & 32'h0000_FEFF);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("count", ndec, r);
		end_sim;
	end
endmodule
